// *** include/pmcr_defs.svh ***
// offsets, field positions, reset values and timing counts for mode control
`ifndef PMCR_DEFS_SVH
`define PMCR_DEFS_SVH
`define PMCR_ADDR_CTRL      5'h00
`define PMCR_ADDR_PAGE      5'h1F
`define PMCR_ADDR_MAIN_LO   5'h10
`define PMCR_ADDR_MAIN_HI   5'h1E
`define PMCR_PAGE_MAIN      16'h0000
`define PMCR_BIT_SRST       15
`define PMCR_BIT_LOOP       14
`define PMCR_BIT_SPD_LSB    13
`define PMCR_BIT_ANEG_EN    12
`define PMCR_BIT_PDOWN      11
`define PMCR_BIT_ISOLATE    10
`define PMCR_BIT_ANEG_RST   9
`define PMCR_BIT_DUPLEX     8
`define PMCR_BIT_COLTEST    7
`define PMCR_BIT_SPD_MSB    6
`define PMCR_CTRL_RESET     16'h1040
`define PMCR_CTRL_WMASK     16'hFFC0
`define PMCR_PAGE_RESET     16'h0000
`define PMCR_SRST_TIME_NS   1000
`define PMCR_CLK_PERIOD_NS  100
`define PMCR_SRST_CYCLES    (`PMCR_SRST_TIME_NS / `PMCR_CLK_PERIOD_NS)
`endif

// *** include/pmcr_pkg.sv ***
// types shared by the mode control register block
package pmcr_pkg;
   typedef enum logic [1:0] {
      PMCR_SPD_10,
      PMCR_SPD_100,
      PMCR_SPD_1000,
      PMCR_SPD_RSVD
   } pmcr_speed_type;

   // management access request as seen by the register bank
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [4:0]  addr;
      logic [15:0] wdata;
   } pmcr_req_type;

   // decoded mode towards the datapath
   typedef struct packed {
      pmcr_speed_type speed;
      logic           full_duplex;
      logic           aneg_en;
      logic           loopback;
      logic           power_down;
      logic           isolate;
      logic           col_test;
   } pmcr_mode_type;
endpackage : pmcr_pkg

// *** rtl/pmcr_srst_seq.sv ***
// soft reset sequencer: holds the reset pulse for the settle time
`timescale 1ns/100ps
`include "pmcr_defs.svh"
module pmcr_srst_seq
   import pmcr_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic start,
   output logic      busy,
   output logic      done
);
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] LAST = CNT_W'(`PMCR_SRST_CYCLES - 1);

   typedef enum logic {PMCR_IDLE, PMCR_RUN} pmcr_sst_type;
   pmcr_sst_type     st_r, st_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;

   // count out the settle time; busy drops after the last count
   always_comb
   begin
      st_nxt   = st_r;
      cnt_nxt  = cnt_r;
      case (st_r)
         PMCR_IDLE:
         begin
            if (start)
            begin
               st_nxt  = PMCR_RUN;
               cnt_nxt = '0;
            end
         end
         PMCR_RUN:
         begin
            if (cnt_r == LAST)
            begin
               st_nxt = PMCR_IDLE;
            end
            else
               cnt_nxt = cnt_r + CNT_W'(1);
         end
         default: st_nxt = PMCR_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_r  <= PMCR_IDLE;
         cnt_r <= '0;
      end
      else
      begin
         st_r  <= st_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign busy = (st_r == PMCR_RUN);
   // done overlaps the last busy cycle, so defaults are back the moment
   // busy falls and the first access after that is never lost
   assign done = busy && (cnt_r == LAST);
endmodule : pmcr_srst_seq

// *** rtl/pmcr_regs.sv ***
// mode control register, page gate and mode decode for the copper port
`timescale 1ns/100ps
`include "pmcr_defs.svh"
module pmcr_regs
   import pmcr_pkg::*;
(
   input  wire logic        CLOCK,
   input  wire logic        RST,
   input  wire logic        MGMT_WR,
   input  wire logic        MGMT_RD,
   input  wire logic [4:0]  MGMT_ADDR,
   input  wire logic [15:0] MGMT_WDATA,
   output logic      [15:0] MGMT_RDATA,
   output logic             MGMT_RVALID,
   output logic             MAIN_PAGE_SEL,
   output logic             MAIN_PAGE_WR,
   output logic             MAIN_PAGE_RD,
   input  wire logic [15:0] MAIN_PAGE_RDATA,
   output logic             SOFT_RESET,
   output logic             ANEG_RESTART,
   output logic [1:0]       LINK_SPEED,
   output logic             LINK_FULL_DUPLEX,
   output logic             ANEG_ENABLE,
   output logic             LOOPBACK_EN,
   output logic             COL_TEST_EN,
   output logic             POWER_DOWN,
   output logic             MAC_OUT_EN,
   output logic             MAC_IN_EN,
   output logic             MEDIA_EN
);
   pmcr_req_type  req;
   pmcr_mode_type mode_r, mode_nxt;
   logic [15:0]   ctrl_r, ctrl_nxt;
   logic [15:0]   page_r, page_nxt;
   logic [15:0]   rdata_r, rdata_nxt;
   logic          rvalid_r, rvalid_nxt;
   logic          aneg_rst_r, aneg_rst_nxt;
   logic          srst_busy, srst_done, srst_start;
   logic          main_hit;

   assign req = '{wr: MGMT_WR, rd: MGMT_RD, addr: MGMT_ADDR,
                  wdata: MGMT_WDATA};

   // page-dependent registers only decode while the page holds zero
   assign main_hit = (page_r == `PMCR_PAGE_MAIN) &&
                     (req.addr >= `PMCR_ADDR_MAIN_LO) &&
                     (req.addr <= `PMCR_ADDR_MAIN_HI);
   assign MAIN_PAGE_SEL = main_hit;
   assign MAIN_PAGE_WR  = main_hit && req.wr && !srst_busy;
   assign MAIN_PAGE_RD  = main_hit && req.rd && !srst_busy;

   // accesses during the settle time are dropped; host must wait anyway
   assign srst_start = req.wr && !srst_busy &&
                       (req.addr == `PMCR_ADDR_CTRL) &&
                       req.wdata[`PMCR_BIT_SRST];

   pmcr_srst_seq pmcr_srst_seq_inst (
      .clk   (CLOCK),
      .rst   (RST),
      .start (srst_start),
      .busy  (srst_busy),
      .done  (srst_done)
   );

   // register writes; soft reset completion restores all defaults
   always_comb
   begin
      ctrl_nxt     = ctrl_r;
      page_nxt     = page_r;
      aneg_rst_nxt = 1'b0;
      if (srst_done)
      begin
         ctrl_nxt = `PMCR_CTRL_RESET;
         page_nxt = `PMCR_PAGE_RESET;
      end
      else if (req.wr && !srst_busy)
      begin
         if (req.addr == `PMCR_ADDR_CTRL)
         begin
            // reserved low bits stay zero whatever is written
            ctrl_nxt = req.wdata & `PMCR_CTRL_WMASK;
            // restart is taken at once, so the bit never stays set
            aneg_rst_nxt = req.wdata[`PMCR_BIT_ANEG_RST];
            ctrl_nxt[`PMCR_BIT_ANEG_RST] = 1'b0;
         end
         else if (req.addr == `PMCR_ADDR_PAGE)
            page_nxt = req.wdata;
      end
      // bit 15 holds one until the sequence completes
      if (srst_busy && !srst_done)
         ctrl_nxt[`PMCR_BIT_SRST] = 1'b1;
   end

   // read data mux; unmapped or gated addresses read as zero
   always_comb
   begin
      rdata_nxt  = 16'h0000;
      rvalid_nxt = req.rd && !srst_busy;
      if (req.rd && !srst_busy)
      begin
         if (req.addr == `PMCR_ADDR_CTRL)
            rdata_nxt = ctrl_r;
         else if (req.addr == `PMCR_ADDR_PAGE)
            rdata_nxt = page_r;
         else if (main_hit)
            rdata_nxt = MAIN_PAGE_RDATA;
      end
   end

   // decode the control word into datapath modes
   always_comb
   begin
      mode_nxt.speed = pmcr_speed_type'({ctrl_r[`PMCR_BIT_SPD_MSB],
                                         ctrl_r[`PMCR_BIT_SPD_LSB]});
      mode_nxt.full_duplex = ctrl_r[`PMCR_BIT_DUPLEX];
      mode_nxt.aneg_en     = ctrl_r[`PMCR_BIT_ANEG_EN];
      mode_nxt.loopback    = ctrl_r[`PMCR_BIT_LOOP];
      mode_nxt.power_down  = ctrl_r[`PMCR_BIT_PDOWN];
      mode_nxt.isolate     = ctrl_r[`PMCR_BIT_ISOLATE];
      mode_nxt.col_test    = ctrl_r[`PMCR_BIT_COLTEST];
   end

   always_ff @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         ctrl_r     <= `PMCR_CTRL_RESET;
         page_r     <= `PMCR_PAGE_RESET;
         rdata_r    <= 16'h0000;
         rvalid_r   <= 1'b0;
         aneg_rst_r <= 1'b0;
         mode_r     <= '{speed: PMCR_SPD_1000, full_duplex: 1'b0,
                         aneg_en: 1'b1, loopback: 1'b0,
                         power_down: 1'b0, isolate: 1'b0,
                         col_test: 1'b0};
      end
      else
      begin
         ctrl_r     <= ctrl_nxt;
         page_r     <= page_nxt;
         rdata_r    <= rdata_nxt;
         rvalid_r   <= rvalid_nxt;
         aneg_rst_r <= aneg_rst_nxt;
         mode_r     <= mode_nxt;
      end
   end

   assign MGMT_RDATA   = rdata_r;
   assign MGMT_RVALID  = rvalid_r;
   assign SOFT_RESET   = srst_busy;
   assign ANEG_RESTART = aneg_rst_r;
   // loopback keeps the selected speed and duplex, nothing is overridden
   assign LINK_SPEED       = mode_r.speed;
   assign LINK_FULL_DUPLEX = mode_r.full_duplex;
   assign ANEG_ENABLE      = mode_r.aneg_en;
   assign LOOPBACK_EN      = mode_r.loopback;
   assign COL_TEST_EN      = mode_r.col_test;
   assign POWER_DOWN       = mode_r.power_down;
   // power-down idles the MAC side as well; management is untouched
   assign MAC_OUT_EN = !mode_r.isolate && !mode_r.power_down;
   assign MAC_IN_EN  = !mode_r.isolate && !mode_r.power_down;
   assign MEDIA_EN   = !mode_r.power_down;

   // assertions
   chk_page_gate: assert property (@(posedge CLOCK) disable iff (RST)
      MAIN_PAGE_SEL |-> (page_r == 16'h0000))
      else $error("main page selected with nonzero page");
   chk_srst_clear: assert property (@(posedge CLOCK) disable iff (RST)
      srst_start |=> SOFT_RESET [*8] ##1 SOFT_RESET [*2] ##1 !SOFT_RESET)
      else $error("soft reset length wrong");
   chk_srst_dflt: assert property (@(posedge CLOCK) disable iff (RST)
      srst_done |=> (ctrl_r == 16'h1040))
      else $error("soft reset did not restore defaults");
   chk_srst_quiet: assert property (@(posedge CLOCK) disable iff (RST)
      SOFT_RESET |-> !MAIN_PAGE_WR && !MAIN_PAGE_RD)
      else $error("access passed during soft reset");
   chk_loop_track: assert property (@(posedge CLOCK) disable iff (RST)
      $rose(LOOPBACK_EN) |-> LINK_SPEED == {$past(ctrl_r[6]),
                                            $past(ctrl_r[13])})
      else $error("loopback speed not current setting");
   chk_speed_map: assert property (@(posedge CLOCK) disable iff (RST)
      ##1 LINK_SPEED == {$past(ctrl_r[6]), $past(ctrl_r[13])})
      else $error("speed decode wrong");
   // a fresh restart write may legally keep the pulse up one more cycle
   chk_aneg_pulse: assert property (@(posedge CLOCK) disable iff (RST)
      ANEG_RESTART && !(MGMT_WR && MGMT_ADDR == 5'h00 && MGMT_WDATA[9])
      |=> !ANEG_RESTART && !ctrl_r[9])
      else $error("restart not self clearing");
   chk_isolate_mac: assert property (@(posedge CLOCK)
      disable iff (RST) ctrl_r[10] |=> !MAC_OUT_EN && !MAC_IN_EN)
      else $error("mac side active in isolate");
   chk_coltest: assert property (@(posedge CLOCK) disable iff (RST)
      ##2 COL_TEST_EN == $past(ctrl_r[7], 1))
      else $error("collision test mismatch");
   chk_aneg_en: assert property (@(posedge CLOCK) disable iff (RST)
      ##1 ANEG_ENABLE == $past(ctrl_r[12]))
      else $error("autoneg enable mismatch");
   chk_pdown_mgmt: assert property (@(posedge CLOCK)
      disable iff (RST) POWER_DOWN && MGMT_RD && !SOFT_RESET |=> MGMT_RVALID)
      else $error("management dead in power-down");
   cov_srst: cover property (@(posedge CLOCK) disable iff (RST)
      srst_start ##[1:20] srst_done);
   cov_main_rd: cover property (@(posedge CLOCK) disable iff (RST)
      MAIN_PAGE_RD);
   cov_loop_gig: cover property (@(posedge CLOCK) disable iff (RST)
      LOOPBACK_EN && LINK_SPEED == 2'b10);
   cov_restart: cover property (@(posedge CLOCK) disable iff (RST)
      ANEG_RESTART);
endmodule : pmcr_regs

// *** verification/pmcr_regs_tb_top.sv ***
// self-checking bench for the mode control register block
`timescale 1ns/100ps
`include "pmcr_defs.svh"
module pmcr_regs_tb_top
   import pmcr_pkg::*;
;
   logic        CLOCK = 1'b0;
   logic        RST, MGMT_WR, MGMT_RD;
   logic [4:0]  MGMT_ADDR;
   logic [15:0] MGMT_WDATA, MAIN_PAGE_RDATA, MGMT_RDATA;
   logic        MGMT_RVALID, MAIN_PAGE_SEL, MAIN_PAGE_WR, MAIN_PAGE_RD;
   logic        SOFT_RESET, ANEG_RESTART, LINK_FULL_DUPLEX, ANEG_ENABLE;
   logic        LOOPBACK_EN, COL_TEST_EN, POWER_DOWN, MAC_OUT_EN;
   logic        MAC_IN_EN, MEDIA_EN;
   logic [1:0]  LINK_SPEED;
   logic [15:0] rd_data;
   logic        rd_valid, sel, fwd;
   int          fail_count = 0;
   int          n_compared = 0;

   pmcr_regs pmcr_regs_inst (.CLOCK(CLOCK), .RST(RST), .MGMT_WR(MGMT_WR),
      .MGMT_RD(MGMT_RD), .MGMT_ADDR(MGMT_ADDR), .MGMT_WDATA(MGMT_WDATA),
      .MGMT_RDATA(MGMT_RDATA), .MGMT_RVALID(MGMT_RVALID),
      .MAIN_PAGE_SEL(MAIN_PAGE_SEL), .MAIN_PAGE_WR(MAIN_PAGE_WR),
      .MAIN_PAGE_RD(MAIN_PAGE_RD), .MAIN_PAGE_RDATA(MAIN_PAGE_RDATA),
      .SOFT_RESET(SOFT_RESET), .ANEG_RESTART(ANEG_RESTART),
      .LINK_SPEED(LINK_SPEED), .LINK_FULL_DUPLEX(LINK_FULL_DUPLEX),
      .ANEG_ENABLE(ANEG_ENABLE), .LOOPBACK_EN(LOOPBACK_EN),
      .COL_TEST_EN(COL_TEST_EN), .POWER_DOWN(POWER_DOWN),
      .MAC_OUT_EN(MAC_OUT_EN), .MAC_IN_EN(MAC_IN_EN), .MEDIA_EN(MEDIA_EN));

   // 10 MHz clock
   always #50 CLOCK = ~CLOCK;

   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit

   // one-cycle write strobe; returns just after the taking edge
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge CLOCK);
      MGMT_WR <= 1'b1;
      MGMT_ADDR <= a;
      MGMT_WDATA <= d;
      #1;
      fwd = MAIN_PAGE_WR;
      @(posedge CLOCK);
      MGMT_WR <= 1'b0;
      #1;
   endtask : wr

   // read answer is registered on the taking edge and sampled just after it
   task automatic rd(input logic [4:0] a);
      @(posedge CLOCK);
      MGMT_RD <= 1'b1;
      MGMT_ADDR <= a;
      #1;
      sel = MAIN_PAGE_SEL;
      fwd = MAIN_PAGE_RD;
      @(posedge CLOCK);
      MGMT_RD <= 1'b0;
      #1;
      rd_valid = MGMT_RVALID;
      rd_data = MGMT_RDATA;
   endtask : rd

   // mode outputs lag the register by one more edge
   task automatic settle();
      @(posedge CLOCK);
      #1;
   endtask : settle

   task automatic t_reset();
      rd(`PMCR_ADDR_CTRL);
      chk_bit(rd_valid, 1'b1);
      chk_word(rd_data, `PMCR_CTRL_RESET);
      rd(`PMCR_ADDR_PAGE);
      chk_word(rd_data, `PMCR_PAGE_RESET);
      chk_word({14'h0000, LINK_SPEED}, 16'h0002);
      chk_bit(ANEG_ENABLE, 1'b1);
      chk_bit(MAC_OUT_EN, 1'b1);
   endtask : t_reset

   // every speed code with autoneg off, then the level bits
   task automatic t_mode();
      logic [15:0] d;
      for (int i = 0; i < 4; i++)
      begin
         d = 16'h0000;
         d[`PMCR_BIT_SPD_MSB] = i[1];
         d[`PMCR_BIT_SPD_LSB] = i[0];
         // role and crossover writes go out before forcing gigabit; neither write reaches a register here
         if (i == 2)
         begin
            wr(5'h09, 16'h0800);
            wr(`PMCR_ADDR_PAGE, 16'h0001);
            wr(5'h13, 16'h0000);
            wr(`PMCR_ADDR_PAGE, `PMCR_PAGE_MAIN);
         end
         wr(`PMCR_ADDR_CTRL, d);
         settle();
         chk_word({14'h0000, LINK_SPEED}, 16'(i));
         chk_bit(ANEG_ENABLE, 1'b0);
      end
      rd(`PMCR_ADDR_CTRL);
      wr(`PMCR_ADDR_CTRL, (rd_data & 16'h003F) | 16'h6180);
      settle();
      chk_bit(LOOPBACK_EN, 1'b1);
      chk_word({14'h0000, LINK_SPEED}, 16'h0001);
      chk_bit(LINK_FULL_DUPLEX, 1'b1);
      chk_bit(COL_TEST_EN, 1'b1);
      rd(`PMCR_ADDR_CTRL);
      chk_word(rd_data, 16'h6180);
      wr(`PMCR_ADDR_CTRL, 16'h0000);
      settle();
      chk_bit(COL_TEST_EN, 1'b0);
      chk_bit(LOOPBACK_EN, 1'b0);
   endtask : t_mode

   task automatic t_power();
      wr(`PMCR_ADDR_CTRL, 16'h0400);
      settle();
      chk_bit(MAC_OUT_EN, 1'b0);
      chk_bit(MAC_IN_EN, 1'b0);
      chk_bit(MEDIA_EN, 1'b1);
      wr(`PMCR_ADDR_CTRL, 16'h0800);
      settle();
      chk_bit(POWER_DOWN, 1'b1);
      chk_bit(MEDIA_EN, 1'b0);
      rd(`PMCR_ADDR_CTRL);
      chk_bit(rd_valid, 1'b1);
      chk_word(rd_data, 16'h0800);
   endtask : t_power

   task automatic t_restart();
      wr(`PMCR_ADDR_CTRL, 16'h1200);
      chk_bit(ANEG_RESTART, 1'b1);
      settle();
      chk_bit(ANEG_RESTART, 1'b0);
      rd(`PMCR_ADDR_CTRL);
      chk_word(rd_data, 16'h1000);
   endtask : t_restart

   // the upper block only answers while page zero is selected
   task automatic t_page();
      wr(`PMCR_ADDR_PAGE, `PMCR_PAGE_MAIN);
      wr(5'h14, 16'h1234);
      chk_bit(fwd, 1'b1);
      rd(5'h14);
      chk_bit(sel & fwd, 1'b1);
      chk_word(rd_data, MAIN_PAGE_RDATA);
      wr(`PMCR_ADDR_PAGE, 16'h0001);
      rd(`PMCR_ADDR_MAIN_HI);
      chk_bit(sel | fwd, 1'b0);
      chk_word(rd_data, 16'h0000);
      wr(5'h14, 16'hFFFF);
      chk_bit(fwd, 1'b0);
      rd(5'h05);
      chk_word(rd_data, 16'h0000);
   endtask : t_page

   // soft reset: accesses dropped while it runs, then defaults back
   task automatic t_srst();
      wr(`PMCR_ADDR_CTRL, 16'h8800);
      chk_bit(SOFT_RESET, 1'b1);
      rd(`PMCR_ADDR_CTRL);
      chk_bit(rd_valid, 1'b0);
      repeat (7) settle();
      chk_bit(SOFT_RESET, 1'b1);
      settle();
      chk_bit(SOFT_RESET, 1'b0);
      // poll bit 15 until it reads zero, bounded so a stuck bit fails
      rd_data = 16'h8000;
      for (int k = 0; k < 4 && rd_data[15]; k++)
         rd(`PMCR_ADDR_CTRL);
      chk_bit(rd_valid, 1'b1);
      chk_word(rd_data, `PMCR_CTRL_RESET);
      rd(`PMCR_ADDR_PAGE);
      chk_word(rd_data, `PMCR_PAGE_RESET);
      chk_bit(POWER_DOWN, 1'b0);
   endtask : t_srst

   task automatic summarize();
      $display("compared=%0d failed=%0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : summarize

   // main sequence
   initial
   begin
      RST = 1'b1;
      MGMT_WR = 1'b0;
      MGMT_RD = 1'b0;
      MGMT_ADDR = 5'h00;
      MGMT_WDATA = 16'h0000;
      MAIN_PAGE_RDATA = 16'hA5C3;
      repeat (6) @(posedge CLOCK);
      RST <= 1'b0;
      t_reset();
      t_mode();
      t_power();
      t_restart();
      t_page();
      t_srst();
      summarize();
   end

   // the run needs under a hundred cycles; this cuts a hang short
   initial
   begin
      #500000;
      fail_count++;
      $display("watchdog expired at t=%0t", $time);
      summarize();
   end
endmodule : pmcr_regs_tb_top
